// ==== design/nvac_mem.sv ====
// Byte array with one write port and a registered read port
module nvac_mem #(
    parameter int unsigned AW = 7,
    parameter int unsigned DW = 8
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata_ff
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= mem[raddr];
        end
    end

endmodule // nvac_mem

// ==== design/nvac_pkg.sv ====
// Types shared by the data memory access block
package nvac_pkg;

    typedef struct packed {
        logic [11:0] paddr;
        logic        pwrite;
        logic [31:0] pwdata;
        logic        psel;
        logic        penable;
    } nvac_apb_req_t;

    typedef struct packed {
        logic master_clear_pin;
        logic watchdog_timeout;
        logic brownout_detect;
    } nvac_rst_src_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_KEY1,
        SEQ_ARMED
    } nvac_seq_t;

endpackage

// ==== design/nvac_regs.svh ====
// Register indices, field positions, reset values and timing counts
// Notes on behaviour
// - Control register holds four low bits; bits 7-4 read zero and ignore writes.
// - Read-start and write-start accept only writes of one; hardware clears them when done.
// - Write-enable bit 2 allows writes; power-up and warm resets clear it, a completed write never does.
// - Abort flag bit 3 sets when master clear, watchdog or brown-out cuts a write.
// - A reset that aborts a write clears the data and address registers.
// - Each completed write sets done flag at bit 7; it stays until software or a warm reset clears it.
// - Unlock port stores nothing, reads zero, only watches the unlock byte writes.
// - Read-start bit 0 loads the addressed byte into data next cycle, then clears.
// - Data register keeps the last fetched byte until a read, a software write or a warm reset.
// - A write starts only after 55h, then AAh to unlock, then write-start set.
// - The unlock sequence must take exactly the expected number of cycles.
// - Write-start bit 1 cannot be set while write-enable is zero.
// - Clearing write-enable after a write has begun does not stop that write.
// - No write may start while the power-up delay timer is running.
// - Data protection is selected by the data-protect fuse programmed to zero.
// - With data protection active the core still reads and writes normally.
// - Address register selects one of 128 bytes by its seven low bits.
// - Each byte write first erases the location, then programs the new value.
// - Write duration comes from an on-chip timer, not from software.
`ifndef NVAC_REGS_SVH
`define NVAC_REGS_SVH

`define NVAC_IDX_FLAG   10'h00c
`define NVAC_IDX_DATA   10'h09a
`define NVAC_IDX_ADDR   10'h09b
`define NVAC_IDX_CTL    10'h09c
`define NVAC_IDX_KEY    10'h09d

`define NVAC_CTL_RD     0
`define NVAC_CTL_WR     1
`define NVAC_CTL_EN     2
`define NVAC_CTL_ERR    3
`define NVAC_FLAG_DONE  7

`define NVAC_DATA_RST   8'h00
`define NVAC_ADDR_RST   8'h00
`define NVAC_BIT_RST    1'b0

`define NVAC_KEY1       8'h55
`define NVAC_KEY2       8'haa
`define NVAC_ERASED     8'hff

`define NVAC_CLK_KHZ    50000
`define NVAC_PWRUP_MS   72
`define NVAC_PWRUP_CYC  (`NVAC_PWRUP_MS * `NVAC_CLK_KHZ)
`define NVAC_WRITE_US   4000
`define NVAC_WRITE_CYC  (`NVAC_WRITE_US * `NVAC_CLK_KHZ / 1000)
`define NVAC_SEQ_GAP    2

`endif

// ==== design/nvac_timer.sv ====
// One-shot down counter with start, abort and a done pulse
module nvac_timer #(
    parameter int unsigned CNT_W = 22
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic [CNT_W-1:0] load,
    // Status
    output logic                  busy_ff,
    output logic                  done_ff
);

    logic [CNT_W-1:0] cnt_ff;
    logic             last;

    assign last = busy_ff && (cnt_ff == CNT_W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
        end else if (abort) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
        end else if (start) begin
            cnt_ff  <= load;
            busy_ff <= 1'b1;
        end else if (busy_ff) begin
            cnt_ff  <= cnt_ff - CNT_W'(1);
            busy_ff <= !last;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= last && !abort && !start;
        end
    end

endmodule // nvac_timer

// ==== design/nvac_top.sv ====
// Data memory access control with its APB register file
`include "nvac_regs.svh"

module nvac_top
    import nvac_pkg::*;
#(
    parameter int unsigned PWRUP_CYCLES = `NVAC_PWRUP_CYC,
    parameter int unsigned WRITE_CYCLES = `NVAC_WRITE_CYC,
    parameter int unsigned SEQ_GAP      = `NVAC_SEQ_GAP,
    parameter int unsigned CNT_W        = 22
) (
    // Clock and power-on reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire nvac_apb_req_t apb_req,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Reset sources and fuse, asynchronous pins
    input  wire nvac_rst_src_t rst_src,
    input  wire logic          data_protect_fuse,
    // Core state, same clock
    input  wire logic          core_asleep,
    // Status
    output logic               nvm_done_flag,
    output logic               ext_access_lock
);

    // Elaboration checks
    if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= (1 << CNT_W)) begin : g_chk_pwr
        $error("PWRUP_CYCLES out of range for CNT_W");
    end
    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << CNT_W)) begin : g_chk_wr
        $error("WRITE_CYCLES out of range for CNT_W");
    end
    if (SEQ_GAP < 2 || SEQ_GAP > 14) begin : g_chk_gap
        $error("SEQ_GAP must lie between 2 and 14");
    end
    if (CNT_W < 2 || CNT_W > 30) begin : g_chk_w
        $error("CNT_W must lie between 2 and 30");
    end

    // Register word decode
    function automatic logic reg_hit(input logic [11:0] a, input logic [9:0] idx);
        return (a[1:0] == 2'b00) && (a[11:2] == idx);
    endfunction

    // Pin synchronisers
    logic [3:0] pin_s1_ff;
    logic [3:0] pin_s2_ff;
    logic       master_clear_pin_s;
    logic       wdt_s;
    logic       bod_s;
    logic       fuse_s;
    logic       warm_rst;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_ff <= 4'h8; // Fuse stage idles unprotected
            pin_s2_ff <= 4'h8;
        end else begin
            pin_s1_ff <= {data_protect_fuse, rst_src};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    assign fuse_s = pin_s2_ff[3];
    assign master_clear_pin_s = pin_s2_ff[2];
    assign wdt_s  = pin_s2_ff[1];
    assign bod_s  = pin_s2_ff[0];

    // Watchdog during sleep only wakes the core
    assign warm_rst = master_clear_pin_s || (wdt_s && !core_asleep) || bod_s;

    // APB phases
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        setup;
    logic        xfer;
    logic        wr_xfer;
    logic        hit_flag;
    logic        hit_data;
    logic        hit_addr;
    logic        hit_ctl;
    logic        hit_key;
    logic        mapped;
    logic [7:0]  wd;

    assign setup    = apb_req.psel && !apb_req.penable;
    assign xfer     = apb_req.psel && apb_req.penable && pready_ff;
    assign wr_xfer  = xfer && apb_req.pwrite && !pslverr_ff;
    assign hit_flag = reg_hit(apb_req.paddr, `NVAC_IDX_FLAG);
    assign hit_data = reg_hit(apb_req.paddr, `NVAC_IDX_DATA);
    assign hit_addr = reg_hit(apb_req.paddr, `NVAC_IDX_ADDR);
    assign hit_ctl  = reg_hit(apb_req.paddr, `NVAC_IDX_CTL);
    assign hit_key  = reg_hit(apb_req.paddr, `NVAC_IDX_KEY);
    assign mapped   = hit_flag || hit_data || hit_addr || hit_ctl || hit_key;
    assign wd       = apb_req.pwdata[7:0];

    // Register state
    logic       done_ff;
    logic [7:0] data_ff;
    logic [7:0] addr_ff;
    logic       rd_ff;
    logic       wr_ff;
    logic       en_ff;
    logic       abort_ff;
    logic       lock_ff;

    // Read multiplexer
    logic [31:0] nxt_prdata;

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (hit_flag) begin
            nxt_prdata[`NVAC_FLAG_DONE] = done_ff;
        end else if (hit_data) begin
            nxt_prdata[7:0] = data_ff;
        end else if (hit_addr) begin
            nxt_prdata[7:0] = addr_ff;
        end else if (hit_ctl) begin
            nxt_prdata[3:0] = {abort_ff, en_ff, wr_ff, rd_ff};
        end
        // Unlock port reads back zero
    end

    // No wait state: answer prepared in setup, taken in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup && !mapped;
            prdata_ff  <= (setup && mapped && !apb_req.pwrite) ? nxt_prdata : 32'h0000_0000;
        end
    end

    // Register write strobes
    logic w_flag;
    logic w_data;
    logic w_addr;
    logic w_ctl;
    logic w_key;

    assign w_flag = wr_xfer && hit_flag;
    assign w_data = wr_xfer && hit_data;
    assign w_addr = wr_xfer && hit_addr;
    assign w_ctl  = wr_xfer && hit_ctl;
    assign w_key  = wr_xfer && hit_key;

    // Cycles between completed transfers
    logic [3:0] gap_ff;
    logic       gap_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_ff <= 4'h0;
        end else if (xfer) begin
            gap_ff <= 4'h1;
        end else if (gap_ff != 4'hf) begin
            gap_ff <= gap_ff + 4'h1;
        end
    end

    assign gap_ok = (gap_ff == SEQ_GAP[3:0]);

    // Unlock sequence tracker
    nvac_seq_t seq_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_ff <= SEQ_IDLE;
        end else if (warm_rst) begin
            seq_ff <= SEQ_IDLE;
        end else if (xfer) begin
            if (w_key && wd == `NVAC_KEY1) begin
                seq_ff <= SEQ_KEY1;
            end else if (seq_ff == SEQ_KEY1 && w_key && wd == `NVAC_KEY2 && gap_ok) begin
                seq_ff <= SEQ_ARMED;
            end else begin
                seq_ff <= SEQ_IDLE;
            end
        end
    end

    // Power-up delay
    logic pwr_arm_ff;
    logic pwr_busy;
    logic pwr_block;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_arm_ff <= 1'b1;
        end else begin
            pwr_arm_ff <= 1'b0;
        end
    end

    nvac_timer #(
        .CNT_W (CNT_W)
    ) u_pwr_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (pwr_arm_ff),
        .abort   (1'b0),
        .load    (PWRUP_CYCLES[CNT_W-1:0]),
        .busy_ff (pwr_busy),
        .done_ff ()
    );

    assign pwr_block = pwr_arm_ff || pwr_busy;

    // Write start decision
    logic wr_go;

    assign wr_go = w_ctl && wd[`NVAC_CTL_WR]
                   && en_ff
                   && seq_ff == SEQ_ARMED && gap_ok
                   && !pwr_block
                   && !wr_ff && !warm_rst;

    // Write timer
    logic wtm_done;

    nvac_timer #(
        .CNT_W (CNT_W)
    ) u_wr_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (wr_go),
        .abort   (warm_rst),
        .load    (WRITE_CYCLES[CNT_W-1:0]),
        .busy_ff (),
        .done_ff (wtm_done)
    );

    // Write-enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= `NVAC_BIT_RST;
        end else if (warm_rst) begin
            en_ff <= `NVAC_BIT_RST;
        end else if (w_ctl) begin
            en_ff <= wd[`NVAC_CTL_EN];
        end
    end

    // Write-start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ff <= `NVAC_BIT_RST;
        end else if (warm_rst) begin
            wr_ff <= `NVAC_BIT_RST;
        end else if (wr_go) begin
            wr_ff <= 1'b1;
        end else if (wtm_done) begin
            wr_ff <= 1'b0;
        end
    end

    // Read-start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff <= `NVAC_BIT_RST;
        end else if (warm_rst) begin
            rd_ff <= `NVAC_BIT_RST;
        end else if (rd_ff) begin
            rd_ff <= 1'b0;
        end else if (w_ctl && wd[`NVAC_CTL_RD]) begin
            rd_ff <= 1'b1;
        end
    end

    // Abort flag, a cut write wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_ff <= `NVAC_BIT_RST;
        end else if (warm_rst && wr_ff) begin
            abort_ff <= 1'b1;
        end else if (w_ctl && !warm_rst) begin
            abort_ff <= wd[`NVAC_CTL_ERR];
        end
    end

    // Done flag, completion wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= `NVAC_BIT_RST;
        end else if (warm_rst) begin
            done_ff <= `NVAC_BIT_RST;
        end else if (wtm_done) begin
            done_ff <= 1'b1;
        end else if (w_flag) begin
            done_ff <= wd[`NVAC_FLAG_DONE];
        end
    end

    // Memory read data
    logic [7:0] mem_rdata;

    // Data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ff <= `NVAC_DATA_RST;
        end else if (warm_rst) begin
            data_ff <= `NVAC_DATA_RST;
        end else if (rd_ff) begin
            data_ff <= mem_rdata;
        end else if (w_data) begin
            data_ff <= wd;
        end
    end

    // Address register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ff <= `NVAC_ADDR_RST;
        end else if (warm_rst) begin
            addr_ff <= `NVAC_ADDR_RST;
        end else if (w_addr) begin
            addr_ff <= wd;
        end
    end

    // Write target captured at start
    logic [6:0] lat_addr_ff;
    logic [7:0] lat_data_ff;
    logic       erase_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_addr_ff <= 7'h00;
            lat_data_ff <= `NVAC_DATA_RST;
        end else if (wr_go) begin
            lat_addr_ff <= addr_ff[6:0];
            lat_data_ff <= data_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_ff <= 1'b0;
        end else begin
            erase_ff <= wr_go;
        end
    end

    // Erase first, program at timer expiry
    logic       mem_we;
    logic [7:0] mem_wdata;

    assign mem_we    = erase_ff || wtm_done;
    assign mem_wdata = erase_ff ? `NVAC_ERASED : lat_data_ff;

    nvac_mem #(
        .AW (7),
        .DW (8)
    ) u_mem (
        .pclk     (pclk),
        .presetn  (presetn),
        .we       (mem_we),
        .waddr    (lat_addr_ff),
        .wdata    (mem_wdata),
        .raddr    (addr_ff[6:0]),
        .rdata_ff (mem_rdata)
    );

    // Protection only shuts out the external programmer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ff <= 1'b0;
        end else begin
            lock_ff <= !fuse_s;
        end
    end

    // Outputs
    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign nvm_done_flag   = done_ff;
    assign ext_access_lock = lock_ff;

endmodule // nvac_top

// ==== verification/nvac_top_properties.sv ====
// Assertions on the data memory access block ports
`include "nvac_regs.svh"
module nvac_top_properties
    import nvac_pkg::*;
(
    // Clock and reset
    input wire logic          pclk,
    input wire logic          presetn,
    // Bus
    input wire nvac_apb_req_t apb_req,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    // Side inputs
    input wire nvac_rst_src_t rst_src,
    input wire logic          data_protect_fuse,
    input wire logic          core_asleep,
    // Status
    input wire logic          nvm_done_flag,
    input wire logic          ext_access_lock
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [9:0] idx;
    logic       rdc, rds, clr, rst;
    logic [2:0] calm_ff;
    assign idx = apb_req.paddr[11:2];
    assign rdc = pready && !apb_req.pwrite;
    assign rds = pready && apb_req.pwrite && idx == `NVAC_IDX_CTL && apb_req.pwdata[0];
    assign clr = pready && apb_req.pwrite && idx == `NVAC_IDX_FLAG && !apb_req.pwdata[7];
    assign rst = rst_src != '0;
    // Edges since the last warm reset request, saturating at four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calm_ff <= 3'h0;
        end else begin
            calm_ff <= rst ? 3'h0 : calm_ff + {2'h0, calm_ff != 3'h4};
        end
    end
    sequence ctl_rd_s;
        rdc && idx == `NVAC_IDX_CTL;
    endsequence
    sequence key_rd_s;
        rdc && idx == `NVAC_IDX_KEY;
    endsequence
    sequence flag_rd_s;
        rdc && idx == `NVAC_IDX_FLAG;
    endsequence
    ctl_high_zero_a: assert property (ctl_rd_s |-> prdata[31:4] == 28'h000_0000)
        else $error("control upper bits not zero");
    key_zero_a: assert property (key_rd_s |-> prdata == '0)
        else $error("unlock port read not zero");
    rd_clear_a: assert property (ctl_rd_s ##0 (!$past(rds) && !$past(rds, 2)) |-> !prdata[0])
        else $error("read start not cleared");
    flag_read_a: assert property (flag_rd_s |-> prdata == {24'h00_0000, $past(nvm_done_flag), 7'h00})
        else $error("flag register read wrong");
    flag_hold_a: assert property (nvm_done_flag && !clr && !rst && calm_ff == 3'h4 |=> nvm_done_flag)
        else $error("done flag dropped");
    warm_clear_a: assert property (rst_src.master_clear_pin [*4] |-> !nvm_done_flag)
        else $error("warm reset left done flag");
    lock_on_a: assert property (!data_protect_fuse [*5] |-> ext_access_lock)
        else $error("protection lock missing");
    lock_off_a: assert property (data_protect_fuse [*5] |-> !ext_access_lock)
        else $error("protection lock spurious");
endmodule // nvac_top_properties

bind nvac_top nvac_top_properties u_nvac_top_properties (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rst_src(rst_src), .data_protect_fuse(data_protect_fuse),
    .core_asleep(core_asleep), .nvm_done_flag(nvm_done_flag), .ext_access_lock(ext_access_lock));

// ==== verification/tb.sv ====
// Self-checking bench for the data memory access block
`include "nvac_regs.svh"
module tb
    import nvac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WRC = 16;
    logic          pclk = 1'b0;
    logic          presetn, data_protect_fuse, core_asleep;
    nvac_apb_req_t apb_req;
    nvac_rst_src_t rst_src;
    logic [31:0]   prdata;
    logic          pready, pslverr, nvm_done_flag, ext_access_lock;
    int            bad_count, total_checks;

    nvac_top #(.PWRUP_CYCLES(40), .WRITE_CYCLES(WRC), .SEQ_GAP(2), .CNT_W(22)) u_nvac_top (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rst_src(rst_src), .data_protect_fuse(data_protect_fuse), .core_asleep(core_asleep),
        .nvm_done_flag(nvm_done_flag), .ext_access_lock(ext_access_lock));

    always #10 pclk = ~pclk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Waits edge by edge for pready or the done flag, bounded
    task automatic wait_hi(input bit done, input int n);
        int i;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while ((done ? nvm_done_flag : pready) !== 1'b1 && i < n);
        if ((done ? nvm_done_flag : pready) !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED at %0t: wait timed out", $time);
            close_out();
        end
    endtask

    // One bus transfer; without rel the next setup follows at once
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] wd, input logic rel,
                        output logic [31:0] rd, output logic err);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= w;
        apb_req.paddr   <= {idx, 2'b00};
        apb_req.pwdata  <= {24'h00_0000, wd};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        wait_hi(1'b0, 5);
        rd = prdata;
        err = pslverr;
        if (rel) begin
            apb_req.psel    <= 1'b0;
            apb_req.penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] wd, input logic rel);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, idx, wd, rel, r, e);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic        e;
        xfer(1'b0, idx, 8'h00, 1'b1, r, e);
        check(r, {24'h00_0000, exp});
    endtask

    task automatic rd_mem(input logic [7:0] a, input logic [7:0] exp);
        wr(`NVAC_IDX_ADDR, a, 1'b0);
        wr(`NVAC_IDX_CTL, 8'h01, 1'b1);
        rd_chk(`NVAC_IDX_DATA, exp);
    endtask

    // Mode 0 exact sequence, 1 read inside, 2 idle gap, 3 enable not set before
    task automatic start_write(input logic [7:0] a, input logic [7:0] d, input int mode);
        logic [31:0] r;
        logic        e;
        wr(`NVAC_IDX_ADDR, a, 1'b0);
        wr(`NVAC_IDX_DATA, d, 1'b0);
        wr(`NVAC_IDX_CTL, (mode == 3) ? 8'h00 : 8'h04, 1'b0);
        wr(`NVAC_IDX_KEY, `NVAC_KEY1, mode == 2);
        if (mode == 1) xfer(1'b0, `NVAC_IDX_KEY, 8'h00, 1'b0, r, e);
        wr(`NVAC_IDX_KEY, `NVAC_KEY2, 1'b0);
        wr(`NVAC_IDX_CTL, 8'h06, 1'b1);
    endtask

    task automatic t_reset;
        logic [31:0] r;
        logic        e;
        rd_chk(`NVAC_IDX_FLAG, 8'h00);
        rd_chk(`NVAC_IDX_DATA, 8'h00);
        rd_chk(`NVAC_IDX_ADDR, 8'h00);
        rd_chk(`NVAC_IDX_CTL, 8'h00);
        rd_chk(`NVAC_IDX_KEY, 8'h00);
        xfer(1'b0, 10'h3ff, 8'h00, 1'b1, r, e);
        check({r[31:1], e}, 32'h0000_0001);
        start_write(8'h05, 8'h5a, 0);
        rd_chk(`NVAC_IDX_CTL, 8'h04);
        $display("test reset values and power-up delay done");
    endtask

    task automatic t_write;
        wr(`NVAC_IDX_CTL, 8'hf4, 1'b1);
        rd_chk(`NVAC_IDX_CTL, 8'h04);
        start_write(8'h85, 8'h5a, 0);
        rd_chk(`NVAC_IDX_CTL, 8'h06);
        wr(`NVAC_IDX_CTL, 8'h00, 1'b1);
        rd_chk(`NVAC_IDX_CTL, 8'h02);
        check({31'h0000_0000, nvm_done_flag}, 32'h0000_0000);
        wait_hi(1'b1, 3 * WRC);
        @(posedge pclk);
        rd_chk(`NVAC_IDX_CTL, 8'h00);
        rd_chk(`NVAC_IDX_FLAG, 8'h80);
        wr(`NVAC_IDX_FLAG, 8'h00, 1'b1);
        rd_chk(`NVAC_IDX_FLAG, 8'h00);
        rd_mem(8'h05, 8'h5a);
        rd_chk(`NVAC_IDX_CTL, 8'h00);
        wr(`NVAC_IDX_ADDR, 8'h10, 1'b1);
        rd_chk(`NVAC_IDX_DATA, 8'h5a);
        $display("test write and read back done");
    endtask

    task automatic t_refuse;
        for (int m = 1; m < 4; m++) begin
            start_write(8'h07, 8'hc3, m);
            rd_chk(`NVAC_IDX_CTL, 8'h04);
            wr(`NVAC_IDX_CTL, 8'h00, 1'b1);
        end
        $display("test refused sequences done");
    endtask

    task automatic t_abort;
        for (int s = 0; s < 3; s++) begin
            start_write(8'h06, 8'h11, 0);
            rst_src <= nvac_rst_src_t'(3'b100 >> s);
            repeat (4) @(posedge pclk);
            rst_src <= '0;
            repeat (4) @(posedge pclk);
            rd_chk(`NVAC_IDX_CTL, 8'h08);
            rd_chk(`NVAC_IDX_DATA, 8'h00);
            rd_chk(`NVAC_IDX_ADDR, 8'h00);
            wr(`NVAC_IDX_CTL, 8'h00, 1'b1);
        end
        rd_mem(8'h06, 8'hff);
        check({31'h0000_0000, nvm_done_flag}, 32'h0000_0000);
        core_asleep <= 1'b1;
        start_write(8'h09, 8'h11, 0);
        rst_src <= nvac_rst_src_t'(3'b010);
        repeat (4) @(posedge pclk);
        rst_src <= '0;
        repeat (4) @(posedge pclk);
        core_asleep <= 1'b0;
        rd_chk(`NVAC_IDX_CTL, 8'h06);
        wait_hi(1'b1, 3 * WRC);
        @(posedge pclk);
        rd_chk(`NVAC_IDX_CTL, 8'h04);
        wr(`NVAC_IDX_FLAG, 8'h00, 1'b1);
        $display("test aborted writes done");
    endtask

    task automatic t_protect;
        data_protect_fuse <= 1'b0;
        repeat (5) @(posedge pclk);
        check({31'h0000_0000, ext_access_lock}, 32'h0000_0001);
        start_write(8'h08, 8'h3c, 0);
        wait_hi(1'b1, 3 * WRC);
        @(posedge pclk);
        rd_mem(8'h08, 8'h3c);
        data_protect_fuse <= 1'b1;
        $display("test protected access done");
    endtask

    initial begin
        presetn           = 1'b0;
        apb_req           = '0;
        rst_src           = '0;
        data_protect_fuse = 1'b1;
        core_asleep       = 1'b0;
        bad_count         = 0;
        total_checks      = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        repeat (20) @(posedge pclk);
        t_write();
        t_refuse();
        t_abort();
        t_protect();
        close_out();
    end
endmodule // tb
